/* dma_ctl.sv */
// DMA global control and per-channel event logic with AXI4-Lite slave.
// Assumes a single 100 MHz clock; event inputs come from same-clock logic.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////

// Overview of operation
// R1: Enable bit 15 turns whole module on; the code gates only grant and active, events still set flags
// R2: Suspend bit 12 holds off all transfers
// R3: Active status bit 11 shows module activity
// R4: Software skips access right after disabling
// R5: Unimplemented control bits read as zero
// R6: Source/destination event enables at bits 23..20
// R7: Block, cell, abort, error enables 19..16
// R8: Enable one permits event interrupt, zero blocks; status bit 0 still sets on any event, enabled or not
// R9: Source done when pointer equals size
// R10: Source half when pointer equals half size
// R11: Eight pending flags in bits 7..0
// R12: Enabled pending raises request; software clears
module dma_ctl
    import dma_ctl_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Transfer engine side
    input  wire logic        xfer_req,
    input  wire logic        xfer_beat,
    input  wire logic        in_flight,
    output logic             xfer_grant,
    // Other channel events, one-cycle pulses
    input  wire logic        dst_done_ev,
    input  wire logic        dst_half_ev,
    input  wire logic        block_done_ev,
    input  wire logic        cell_done_ev,
    input  wire logic        abort_ev,
    input  wire logic        addr_error_ev,
    // Interrupt
    output logic             irq
);

////////////////////////////////////////////////////////////////////////////////

    typedef struct packed
    {
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        enable;
        logic        suspend;
        logic [7:0]  ev_en;
        logic [15:0] src_size;
        logic [15:0] src_ptr;
        logic        src_done_seen;
        logic        src_half_seen;
        logic [1:0]  irq_status;
        logic [1:0]  irq_mask;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;

    logic [NUM_EVENTS-1:0] pending;
    logic [NUM_EVENTS-1:0] ev_pulse;
    logic                  chan_irq;
    logic                  active;
    logic                  wr_fire;
    logic                  pend_we;
    logic [31:0]           wmask;
    logic                  src_done_hit;
    logic                  src_half_hit;
    logic [1:0]            irq_set;
    logic [31:0]           size_wr;
    logic [31:0]           ptr_wr;
    logic [31:0]           mask_wr;

    // Byte strobes to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // Merge a write under the byte mask
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    // Offset decode, shared by reads and writes
    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == OFF_GLOBAL_CTRL) || (a == OFF_EVENT_CTRL) ||
                     (a == OFF_SRC_SIZE) || (a == OFF_SRC_PTR) ||
                     (a == OFF_IRQ_STATUS) || (a == OFF_IRQ_MASK);
    endfunction

////////////////////////////////////////////////////////////////////////////////

    // Gate the engine by enable and suspend
    bus_gate u_gate
    (
        .module_en  (s_q.enable),
        .suspend    (s_q.suspend),
        .xfer_req   (xfer_req),
        .in_flight  (in_flight),
        .xfer_grant (xfer_grant),
        .active     (active)
    );

    // Pointer comparisons for the source events
    assign src_done_hit = (s_q.src_ptr == s_q.src_size) && !s_q.src_done_seen;      // R9
    assign src_half_hit = (s_q.src_ptr == {1'b0, s_q.src_size[15:1]})
                          && !s_q.src_half_seen && (s_q.src_size != RST_SRC_SIZE);  // R10

    // Events gathered in enable order
    always_comb
    begin
        ev_pulse                = '0;
        ev_pulse[EV_SRC_DONE]   = src_done_hit && s_q.src_size != RST_SRC_SIZE;
        ev_pulse[EV_SRC_HALF]   = src_half_hit;
        ev_pulse[EV_DST_DONE]   = dst_done_ev;
        ev_pulse[EV_DST_HALF]   = dst_half_ev;
        ev_pulse[EV_BLOCK_DONE] = block_done_ev;
        ev_pulse[EV_CELL_DONE]  = cell_done_ev;
        ev_pulse[EV_ABORT]      = abort_ev;
        ev_pulse[EV_ADDR_ERROR] = addr_error_ev;
    end

    assign wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    assign wmask   = strb_mask(s_q.w_strb);
    assign pend_we = wr_fire && (s_q.aw_addr == OFF_EVENT_CTRL) && s_q.w_strb[0];

    // Lane merges for the narrow registers; upper lanes fall away on purpose
    assign size_wr = merge({16'h0000, s_q.src_size}, s_q.w_data, wmask);
    assign ptr_wr  = merge({16'h0000, s_q.src_ptr}, s_q.w_data, wmask);
    assign mask_wr = merge({30'h0, s_q.irq_mask}, s_q.w_data, wmask);

    // Pending flags and their enables
    event_flags u_flags
    (
        .clk        (clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .ev_pulse   (ev_pulse),
        .pend_we    (pend_we),
        .pend_wdata (s_q.w_data[POS_PEND_LO +: NUM_EVENTS]),
        .enables    (s_q.ev_en),
        .pending    (pending),
        .irq_req    (chan_irq)
    );

    // Sticky sources: channel request and any channel event, enabled or not
    assign irq_set = {chan_irq, |ev_pulse};

////////////////////////////////////////////////////////////////////////////////

    // Bus handshake, register writes, pointer and status
    always_comb
    begin
        s_d = s_q;

        // Capture address and data independently
        if (s_axi_awvalid && !s_q.aw_held)
        begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_held)
        begin
            s_d.w_held = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end

        // Commit a write once both halves are held
        if (wr_fire)
        begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = known_addr(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            case (s_q.aw_addr)
                OFF_GLOBAL_CTRL:
                begin
                    if (s_q.w_strb[1])
                    begin
                        s_d.enable  = s_q.w_data[POS_ENABLE];       // R1
                        s_d.suspend = s_q.w_data[POS_SUSPEND];      // R2
                    end
                end
                OFF_EVENT_CTRL:
                begin
                    if (s_q.w_strb[2])
                    begin
                        s_d.ev_en = s_q.w_data[POS_EN_LO +: NUM_EVENTS];  // R6 R7
                    end
                end
                OFF_SRC_SIZE:
                begin
                    s_d.src_size      = size_wr[15:0];
                    s_d.src_done_seen = 1'b0;
                    s_d.src_half_seen = 1'b0;
                end
                OFF_SRC_PTR:
                begin
                    s_d.src_ptr       = ptr_wr[15:0];
                    s_d.src_done_seen = 1'b0;
                    s_d.src_half_seen = 1'b0;
                end
                OFF_IRQ_STATUS:
                begin
                    s_d.irq_status = s_q.irq_status & ~(s_q.w_data[1:0] & wmask[1:0]);
                end
                OFF_IRQ_MASK:
                begin
                    s_d.irq_mask = mask_wr[1:0];
                end
                default:
                begin
                    s_d.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (s_q.bvalid && s_axi_bready)
        begin
            s_d.bvalid = 1'b0;
        end

        // Reads answer one cycle after the address is taken
        if (s_axi_arvalid && !s_q.rvalid)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                // Reserved positions stay zero; only the named fields are filled
                OFF_GLOBAL_CTRL:
                begin
                    s_d.rdata              = 32'h0000_0000;                   // R5
                    s_d.rdata[POS_ENABLE]  = s_q.enable;
                    s_d.rdata[POS_SUSPEND] = s_q.suspend;
                    s_d.rdata[POS_ACTIVE]  = active;                          // R3
                end
                OFF_EVENT_CTRL:
                begin
                    s_d.rdata                            = 32'h0000_0000;
                    s_d.rdata[POS_EN_LO +: NUM_EVENTS]   = s_q.ev_en;
                    s_d.rdata[POS_PEND_LO +: NUM_EVENTS] = pending;           // R11
                end
                OFF_SRC_SIZE:    s_d.rdata = {16'h0000, s_q.src_size};
                OFF_SRC_PTR:     s_d.rdata = {16'h0000, s_q.src_ptr};
                OFF_IRQ_STATUS:  s_d.rdata = {30'h0, s_q.irq_status};
                OFF_IRQ_MASK:    s_d.rdata = {30'h0, s_q.irq_mask};
                default:         s_d.rdata = 32'h0000_0000;
            endcase
        end
        else if (s_q.rvalid && s_axi_rready)
        begin
            s_d.rvalid = 1'b0;
        end

        // Pointer advances on each granted beat
        // A beat in the cycle of a pointer write wins, so no beat is lost
        if (xfer_beat && xfer_grant)
        begin
            s_d.src_ptr = s_q.src_ptr + 16'h0001;
        end
        if (src_done_hit)
        begin
            s_d.src_done_seen = 1'b1;
        end
        if (src_half_hit)
        begin
            s_d.src_half_seen = 1'b1;
        end

        // Set wins over the write-one clear
        s_d.irq_status = s_d.irq_status | irq_set;
    end

    // Single register stage for all state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_q            <= '0;
            s_q.enable     <= RST_GLOBAL_CTRL[POS_ENABLE];
            s_q.suspend    <= RST_GLOBAL_CTRL[POS_SUSPEND];
            s_q.ev_en      <= RST_EVENT_CTRL[POS_EN_LO +: NUM_EVENTS];
            s_q.src_size   <= RST_SRC_SIZE;
            s_q.src_ptr    <= RST_SRC_PTR;
            s_q.irq_status <= RST_IRQ;
            s_q.irq_mask   <= RST_IRQ;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

////////////////////////////////////////////////////////////////////////////////

    // Bus outputs; ready only while the slot is free
    assign s_axi_awready = !s_q.aw_held && ce;
    assign s_axi_wready  = !s_q.w_held && ce;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid && ce;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;

    // Level interrupt from unmasked sticky bits
    assign irq = |(s_q.irq_status & s_q.irq_mask);

endmodule

/* dma_ctl_pkg.sv */
// Package for the DMA global control and channel event block.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
package dma_ctl_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_GLOBAL_CTRL  = 8'h00;
    localparam logic [7:0] OFF_EVENT_CTRL   = 8'h04;
    localparam logic [7:0] OFF_SRC_SIZE     = 8'h08;
    localparam logic [7:0] OFF_SRC_PTR      = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STATUS   = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK     = 8'h14;

    // Global control field positions
    localparam int POS_ENABLE  = 15;
    localparam int POS_SUSPEND = 12;
    localparam int POS_ACTIVE  = 11;

    // Event register layout: enables at 23..16, pending at 7..0
    localparam int POS_EN_LO   = 16;
    localparam int POS_PEND_LO = 0;
    localparam int NUM_EVENTS  = 8;

    // Event bit order inside each byte
    localparam int EV_SRC_DONE   = 7;
    localparam int EV_SRC_HALF   = 6;
    localparam int EV_DST_DONE   = 5;
    localparam int EV_DST_HALF   = 4;
    localparam int EV_BLOCK_DONE = 3;
    localparam int EV_CELL_DONE  = 2;
    localparam int EV_ABORT      = 1;
    localparam int EV_ADDR_ERROR = 0;

    // Reset values
    localparam logic [31:0] RST_GLOBAL_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_EVENT_CTRL  = 32'h0000_0000;
    localparam logic [15:0] RST_SRC_SIZE    = 16'h0000;
    localparam logic [15:0] RST_SRC_PTR     = 16'h0000;
    localparam logic [1:0]  RST_IRQ         = 2'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* event_flags.sv */
// Channel event pending flags with per-event enables.
// Assumes one-cycle event pulses from same-clock logic.
`timescale 1ns/1ns
module event_flags
    import dma_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    // Event pulses
    input  wire logic [NUM_EVENTS-1:0] ev_pulse,
    // Software write of the pending byte
    input  wire logic                  pend_we,
    input  wire logic [NUM_EVENTS-1:0] pend_wdata,
    input  wire logic [NUM_EVENTS-1:0] enables,
    // State
    output logic      [NUM_EVENTS-1:0] pending,
    output logic                       irq_req
);

    typedef struct packed
    {
        logic [NUM_EVENTS-1:0] pend;
    } flag_state_t;

    flag_state_t s_q;
    flag_state_t s_d;

    // Software writes the byte; a new event wins over a clear
    always_comb
    begin
        s_d = s_q;
        if (pend_we)
        begin
            s_d.pend = pend_wdata;                                  // R12
        end
        s_d.pend = s_d.pend | ev_pulse;                             // R11
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    assign pending = s_q.pend;
    // Enabled pending flags request service
    assign irq_req = |(s_q.pend & enables);                         // R8 R12

endmodule

/* bus_gate.sv */
// Transfer gate: decides whether the engine may use the data bus.
// Assumes the caller supplies a transfer request level.
`timescale 1ns/1ns
module bus_gate
(
    // Controls
    input  wire logic module_en,
    input  wire logic suspend,
    input  wire logic xfer_req,
    input  wire logic in_flight,
    // Results
    output logic      xfer_grant,
    output logic      active
);

    // Disabled or suspended module never starts a transfer
    assign xfer_grant = module_en && !suspend && xfer_req;          // R1 R2
    // Busy while on, or while a beat is still draining
    assign active     = module_en || in_flight;                     // R3

endmodule

/* dma_ctl_assertions.sv */
// Checker for the DMA control block: bus timing, reserved bits, interrupt.
// Assumes it is bound to dma_ctl and sees only that module's ports.
`timescale 1ns/1ns
module dma_ctl_checker
    import dma_ctl_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Engine and interrupt
    input wire logic        xfer_req,
    input wire logic        xfer_grant,
    input wire logic        irq
);
    logic [7:0] ar_q;

    // Address of the read being answered; read data alone cannot tell which register
    always_ff @(posedge clk)
    begin
        if (s_axi_arvalid && s_axi_arready)
        begin
            ar_q <= s_axi_araddr;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    AST_GRANT_REQ: assert property (xfer_grant |-> xfer_req)
        else $error("grant without request");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    AST_CTRL_RSV: assert property (s_axi_rvalid && ar_q == OFF_GLOBAL_CTRL |-> (s_axi_rdata & 32'hffff_67ff) == 32'h0)
        else $error("control reserved bits not zero");
    AST_EV_RSV: assert property (s_axi_rvalid && ar_q == OFF_EVENT_CTRL |-> (s_axi_rdata & 32'hff00_ff00) == 32'h0)
        else $error("event reserved bits not zero");
    AST_UNMAPPED: assert property (s_axi_rvalid && ar_q > OFF_IRQ_MASK |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_IRQ_STICKY: assert property (irq |=> irq || s_axi_bvalid || $past(s_axi_wvalid))
        else $error("interrupt dropped without a write");
endmodule

bind dma_ctl dma_ctl_checker u_chk (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .xfer_req, .xfer_grant, .irq);

/* bus_partner.sv */
// Model of the transfer engine that shares the system data bus.
// Assumes the bench loads a beat count with a one-cycle start pulse.
`timescale 1ns/1ns
module bus_partner
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Bench commands
    input  wire logic        start,
    input  wire logic [15:0] beats,
    input  wire logic        slow,
    // Engine side of the block
    input  wire logic        xfer_grant,
    output logic             xfer_req,
    output logic             xfer_beat,
    output logic             in_flight
);
    logic [15:0] left_q;
    logic        phase_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Request held until all beats moved; slow mode moves only every other cycle
    assign xfer_req  = (left_q != 16'h0);
    assign xfer_beat = xfer_req && xfer_grant && (!slow || phase_q);

    // Beat count and drain flag
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            left_q    <= 16'h0;
            phase_q   <= 1'b0;
            in_flight <= 1'b0;
        end
        else
        begin
            phase_q   <= !phase_q;
            in_flight <= xfer_beat; // Beat still draining next cycle
            if (start)
                left_q <= beats;
            else if (xfer_beat)
                left_q <= left_q - 16'h1;
        end
    end
endmodule

/* testbench.sv */
// Testbench for the DMA control block: register tests over AXI4-Lite.
// Assumes the transfer engine is the bus_partner model.
`timescale 1ns/1ns
`define CHK(nm, got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module testbench
    import dma_ctl_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic start = 1'b0, slow = 1'b1, xfer_req, xfer_beat, in_flight, xfer_grant;
    logic [15:0] beats = 16'h0;
    logic [5:0] ev = 6'h0;
    int n_errors = 0, check_count = 0, i;

    always #5 clk = ~clk;

    dma_ctl dut (.clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .xfer_req, .xfer_beat,
        .in_flight, .xfer_grant, .dst_done_ev(ev[5]), .dst_half_ev(ev[4]), .block_done_ev(ev[3]),
        .cell_done_ev(ev[2]), .abort_ev(ev[1]), .addr_error_ev(ev[0]), .irq);
    bus_partner partner (.clk, .rst_n, .start, .beats, .slow, .xfer_grant, .xfer_req, .xfer_beat, .in_flight);

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // A wait that ran out counts as a mismatch
    task automatic stall();
        n_errors++;
        $display("mismatch timeout expected answer seen none");
        results();
    endtask

    // Write: address and data offered together, each released when taken
    // Response ready stays high afterwards, so back-to-back calls never toggle it in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit done = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (int k = 0; k < 50 && !done; k++)
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                `CHK("bresp", s_axi_bresp, er)
                done = 1;
            end
        end
        if (!done)
            stall();
    endtask

    // Read: data and response taken at the edge where rvalid is seen
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit done = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (int k = 0; k < 50 && !done; k++)
        begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                `CHK("rdata", s_axi_rdata, ed)
                `CHK("rresp", s_axi_rresp, er)
                done = 1;
            end
        end
        if (!done)
            stall();
    endtask

    // Status read synchronises the interrupt sample
    task automatic irq_chk(input logic [31:0] st, input logic exp);
        rd(OFF_IRQ_STATUS, st, RESP_OKAY);
        `CHK("irq", irq, exp)
    endtask

    // One-cycle event pulse
    task automatic pulse(input logic [5:0] p);
        ev <= p;
        @(posedge clk);
        ev <= 6'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 6; i++)
            rd(8'(i * 4), 32'h0, RESP_OKAY);
        $display("test reset values done");
        wr(OFF_GLOBAL_CTRL, 32'hffff_ffff, RESP_OKAY);
        rd(OFF_GLOBAL_CTRL, 32'h0000_9800, RESP_OKAY);
        wr(OFF_GLOBAL_CTRL, 32'h0, RESP_OKAY);
        @(posedge clk);
        rd(OFF_GLOBAL_CTRL, 32'h0, RESP_OKAY);
        wr(8'h20, 32'h1, RESP_SLVERR);
        rd(8'h20, 32'h0, RESP_SLVERR);
        $display("test control done");
        // Engine asks while disabled, then while suspended, then runs
        wr(OFF_SRC_SIZE, 32'h8, RESP_OKAY);
        start <= 1'b1;
        beats <= 16'h8;
        @(posedge clk);
        start <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK("grant", xfer_grant, 1'b0)
        rd(OFF_SRC_PTR, 32'h0, RESP_OKAY);
        wr(OFF_GLOBAL_CTRL, 32'h0000_9000, RESP_OKAY);
        repeat (10) @(posedge clk);
        `CHK("grant", xfer_grant, 1'b0)
        rd(OFF_SRC_PTR, 32'h0, RESP_OKAY);
        rd(OFF_GLOBAL_CTRL, 32'h0000_9800, RESP_OKAY);
        wr(OFF_GLOBAL_CTRL, 32'h0000_8000, RESP_OKAY);
        `CHK("grant", xfer_grant, 1'b1)
        for (i = 0; i < 100 && xfer_req !== 1'b0; i++)
            @(posedge clk);
        if (xfer_req !== 1'b0)
            stall();
        rd(OFF_SRC_PTR, 32'h8, RESP_OKAY);
        rd(OFF_EVENT_CTRL, 32'h0000_00c0, RESP_OKAY);
        $display("test transfer done");
        for (i = 0; i < 6; i++)
        begin
            wr(OFF_EVENT_CTRL, 32'h00ff_0000, RESP_OKAY);
            pulse(6'(1 << i));
            rd(OFF_EVENT_CTRL, 32'h00ff_0000 | (32'h1 << i), RESP_OKAY);
        end
        $display("test event flags done");
        wr(OFF_EVENT_CTRL, 32'h0, RESP_OKAY);
        wr(OFF_IRQ_STATUS, 32'h3, RESP_OKAY);
        wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
        pulse(6'h02);
        irq_chk(32'h1, 1'b0);
        wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
        irq_chk(32'h1, 1'b1);
        wr(OFF_IRQ_MASK, 32'h2, RESP_OKAY);
        irq_chk(32'h1, 1'b0);
        wr(OFF_EVENT_CTRL, 32'h0002_0002, RESP_OKAY);
        irq_chk(32'h3, 1'b1);
        wr(OFF_EVENT_CTRL, 32'h0002_0000, RESP_OKAY);
        irq_chk(32'h3, 1'b1);
        wr(OFF_IRQ_STATUS, 32'h3, RESP_OKAY);
        irq_chk(32'h0, 1'b0);
        // Frozen by the clock enable: the event is lost and the bus refuses
        ce <= 1'b0;
        pulse(6'h01);
        `CHK("awready", s_axi_awready, 1'b0)
        ce <= 1'b1;
        irq_chk(32'h0, 1'b0);
        rd(OFF_EVENT_CTRL, 32'h0002_0000, RESP_OKAY);
        $display("test interrupt done");
        results();
    end
endmodule
